// File: include/usb_ep_in_pkg.sv
// Package for the endpoint 1-3 IN control block: offsets, fields, resets, types.
// Assumes a byte-wide register port and a packet engine that reports token events.
package usb_ep_in_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [7:0] OFS_INDEX = 8'h0E;
    localparam logic [7:0] OFS_IN_CTRL_LOW = 8'h11;
    localparam logic [7:0] OFS_IN_CTRL_HIGH = 8'h12;
    localparam logic [7:0] OFS_ENABLE_MASK = 8'h1E;
    localparam logic [7:0] OFS_UPDATE_CTRL = 8'h0F;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int B_LOW_READY = 0;
    localparam int B_LOW_FIFO_BUSY = 1;
    localparam int B_LOW_UNDERRUN = 2;
    localparam int B_LOW_FLUSH = 3;
    localparam int B_LOW_SEND_STALL = 4;
    localparam int B_LOW_STALL_SENT = 5;
    localparam int B_LOW_CLEAR_TOGGLE = 6;
    localparam int B_HIGH_DBL_BUF = 7;
    localparam int B_HIGH_ISO = 6;
    localparam int B_HIGH_DIR_IN = 5;
    localparam int B_HIGH_SPLIT = 2;
    localparam int B_HIGH_FORCE_TOGGLE = 3;
    localparam int B_UPD_ISO_UPDATE = 7;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] RST_ENABLE_MASK = 8'hFF;
    localparam logic [7:0] ENABLE_FIXED_ONES = 8'hF1;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] RST_INDEX = 2'h0;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        HS_NONE = 2'h0,
        HS_DATA = 2'h1,
        HS_ZLP = 2'h3,
        HS_STALL = 2'h2
    } reply_e;

    typedef struct packed {
        logic [1:0] ep;
        logic token;
        logic ack;
        logic sof;
    } link_ev_s;

    typedef struct packed {
        logic [1:0] slots;
        logic ready;
        logic underrun;
        logic send_stall;
        logic stall_sent;
        logic toggle;
        logic dbl;
        logic iso;
        logic dir_in;
        logic split;
        logic force_tog;
        logic held;
        logic [1:0] pend_ep;
    } ep_s;

    typedef struct packed {
        ep_s [3:1] ep;
        logic [3:1] enable;
        logic [1:0] index;
        logic iso_update;
        logic [7:0] rdata;
        logic [3:1] irq;
        reply_e reply;
        logic toggle_out;
    } state_s;

endpackage : usb_ep_in_pkg

// File: hdl/usb_endpoint_in_control.sv
// Endpoint 1-3 IN control: banked control registers, enables, stall, toggle, ISO.
// Assumes the packet engine presents one-cycle token, ack and sof events on MCLK.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module usb_endpoint_in_control
    import usb_ep_in_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire link_ev_s LINK,
    input wire logic [3:1] FIFO_BYTES,
    output reply_e REPLY,
    output logic REPLY_TOGGLE,
    output logic [3:1] IN_IRQ,
    output logic [3:1] SPLIT_ON,
    output logic [3:1] DIR_IN
);

    state_s s_q;
    state_s s_d;

    always_comb begin
        logic [1:0] sel;
        logic wr_low;
        logic wr_high;
        logic [7:0] low_rd;
        logic [7:0] high_rd;
        ep_s e;
        s_d = s_q;
        sel = s_q.index;
        wr_low = WR && ADDR == OFS_IN_CTRL_LOW && sel != 2'h0;
        wr_high = WR && ADDR == OFS_IN_CTRL_HIGH && sel != 2'h0;
        s_d.irq = 3'h0;
        s_d.reply = HS_NONE;
        e = '0;
        low_rd = 8'h00;
        high_rd = 8'h00;
        if (WR && ADDR == OFS_INDEX) begin
            s_d.index = WDATA[1:0];
        end
        if (WR && ADDR == OFS_UPDATE_CTRL) begin
            s_d.iso_update = WDATA[B_UPD_ISO_UPDATE];
        end
        if (WR && ADDR == OFS_ENABLE_MASK) begin
            s_d.enable = WDATA[3:1];
        end
        for (int i = 1; i <= 3; i++) begin
            e = s_q.ep[i];
            // ********************************************************
            // Register writes, only to the indexed endpoint
            // ********************************************************
            // Banked write decode
            if (wr_high && sel == 2'(i)) begin
                e.dbl = WDATA[B_HIGH_DBL_BUF];
                e.iso = WDATA[B_HIGH_ISO];
                e.dir_in = WDATA[B_HIGH_DIR_IN];
                e.split = WDATA[B_HIGH_SPLIT];
                e.force_tog = WDATA[B_HIGH_FORCE_TOGGLE];
            end
            if (wr_low && sel == 2'(i)) begin
                e.send_stall = WDATA[B_LOW_SEND_STALL];
                if (!WDATA[B_LOW_STALL_SENT]) begin
                    e.stall_sent = 1'b0;
                end
                if (!WDATA[B_LOW_UNDERRUN]) begin
                    e.underrun = 1'b0;
                end
                if (WDATA[B_LOW_CLEAR_TOGGLE]) begin
                    e.toggle = 1'b0;
                end
                if (WDATA[B_LOW_FLUSH]) begin
                    if (e.slots != 2'h0) begin
                        s_d.irq[i] = 1'b1;
                    end
                    e.slots = 2'h0;
                    e.ready = 1'b0;
                end
                // Loading a packet takes a slot
                if (WDATA[B_LOW_READY] && !e.ready) begin
                    e.slots = e.slots + 2'h1;
                    e.ready = 1'b1;
                    // Hold new iso packet to SOF
                    e.held = s_q.iso_update && e.iso;
                end
            end
            // Release held packet at frame start
            if (LINK.sof) begin
                e.held = 1'b0;
            end
            // ********************************************************
            // Token handling
            // ********************************************************
            // A host ACK only answers the packet just sent, so stale marks go
            if (LINK.token) begin
                e.pend_ep = 2'h0;
            end
            if (LINK.token && LINK.ep == 2'(i) && s_q.enable[i]
                && (e.split || e.dir_in)) begin
                if (e.send_stall) begin
                    s_d.reply = HS_STALL;
                    e.stall_sent = 1'b1;
                    s_d.irq[i] = 1'b1;
                end else if (e.slots != 2'h0 && !e.held) begin
                    s_d.reply = FIFO_BYTES[i] ? HS_DATA : HS_ZLP;
                    s_d.toggle_out = e.toggle;
                    e.pend_ep = 2'(i);
                    e.slots = e.slots - 2'h1;
                    s_d.irq[i] = 1'b1;
                    if (e.force_tog) begin
                        e.toggle = !e.toggle;
                    end
                end else if (e.iso) begin
                    s_d.reply = HS_ZLP;
                    s_d.toggle_out = e.toggle;
                    e.underrun = 1'b1;
                    e.pend_ep = 2'(i);
                    if (e.force_tog) begin
                        e.toggle = !e.toggle;
                    end
                end
            end
            if (LINK.ack && e.pend_ep == 2'(i)) begin
                if (!e.force_tog) begin
                    e.toggle = !e.toggle;
                end
                e.pend_ep = 2'h0;
            end
            // Ready drops when a slot is free
            if (e.ready && (e.slots < 2'h2) && (e.dbl || e.slots == 2'h0)) begin
                e.ready = 1'b0;
            end
            s_d.ep[i] = e;
        end
        // ********************************************************
        // Read mux
        // ********************************************************
        if (sel != 2'h0) begin
            e = s_q.ep[sel];
            low_rd = {1'b0, 1'b0, e.stall_sent, e.send_stall, 1'b0,
                      e.underrun, e.slots != 2'h0, e.ready};
            high_rd = {e.dbl, e.iso, e.dir_in, 1'b0, e.force_tog, e.split, 2'h0};
        end
        s_d.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                OFS_INDEX: s_d.rdata = {6'h00, s_q.index};
                OFS_IN_CTRL_LOW: s_d.rdata = low_rd;
                OFS_IN_CTRL_HIGH: s_d.rdata = high_rd;
                OFS_ENABLE_MASK: s_d.rdata = ENABLE_FIXED_ONES | {4'h0, s_q.enable, 1'b0};
                OFS_UPDATE_CTRL: s_d.rdata = {s_q.iso_update, 7'h00};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.enable <= RST_ENABLE_MASK[3:1];
            s_q.index <= RST_INDEX;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign RDATA = s_q.rdata;
    assign IN_IRQ = s_q.irq;
    assign REPLY = s_q.reply;
    assign REPLY_TOGGLE = s_q.toggle_out;
    for (genvar g = 1; g <= 3; g++) begin : g_cfg
        assign SPLIT_ON[g] = s_q.ep[g].split;
        assign DIR_IN[g] = s_q.ep[g].dir_in;
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_disabled_silent: assert property (
        LINK.token && !s_q.enable[LINK.ep] && LINK.ep != 2'h0 |=> REPLY == HS_NONE)
        else $error("Disabled endpoint answered");
    a_stall_reply: assert property (
        LINK.token && LINK.ep == 2'h1 && s_q.enable[1] && s_q.ep[1].send_stall
        && (s_q.ep[1].split || s_q.ep[1].dir_in) |=> REPLY == HS_STALL && IN_IRQ[1])
        else $error("Stall not sent");
    a_stall_flag: assert property (
        REPLY == HS_STALL |-> s_q.ep[1].stall_sent || s_q.ep[2].stall_sent
        || s_q.ep[3].stall_sent)
        else $error("Stall flag not set");
    a_enable_read: assert property (
        RD && ADDR == OFS_ENABLE_MASK |=> RDATA[7:4] == 4'hF && RDATA[0])
        else $error("Enable fixed bits wrong");
    a_clear_toggle: assert property (
        WR && ADDR == OFS_IN_CTRL_LOW && s_q.index == 2'h2 && WDATA[6]
        && !LINK.ack && !LINK.token |=> !s_q.ep[2].toggle)
        else $error("Toggle not cleared");
    a_low_bit6_zero: assert property (
        RD && ADDR == OFS_IN_CTRL_LOW |=> !RDATA[6])
        else $error("Clear-toggle reads one");
    a_iso_underrun: assert property (
        REPLY == HS_ZLP && $past(s_q.ep[3].iso) && $past(s_q.ep[3].slots) == 2'h0
        && $past(LINK.ep) == 2'h3 |-> s_q.ep[3].underrun)
        else $error("Underrun not flagged");
    a_forced_toggle: assert property (
        REPLY == HS_DATA && $past(LINK.ep) == 2'h1 && s_q.ep[1].force_tog
        |-> s_q.ep[1].toggle != REPLY_TOGGLE)
        else $error("Forced toggle missing");
    a_held_no_send: assert property (
        s_q.ep[1].held && LINK.token && LINK.ep == 2'h1 && !LINK.sof
        |=> REPLY != HS_DATA)
        else $error("Held packet sent early");

    // ********************************************************
    // Further checks
    // ********************************************************
    // Reply only after token
    a_reply_needs_token: assert property (
        !LINK.token |=> REPLY == HS_NONE)
        else $error("Reply without token");
    a_rdata_idle: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("Read data without read");
    a_bank_zero_read: assert property (
        RD && ADDR == OFS_IN_CTRL_LOW && s_q.index == 2'h0 |=> RDATA == 8'h00)
        else $error("Unbanked read not zero");
    a_stall_reply_two: assert property (
        LINK.token && LINK.ep == 2'h2 && s_q.enable[2] && s_q.ep[2].send_stall
        && s_q.ep[2].dir_in && !WR |=> REPLY == HS_STALL && IN_IRQ[2])
        else $error("Stall not sent on two");
    a_stall_flag_two: assert property (
        LINK.token && LINK.ep == 2'h2 && s_q.enable[2] && s_q.ep[2].send_stall
        && s_q.ep[2].dir_in && !WR |=> s_q.ep[2].stall_sent)
        else $error("Stall flag not set on two");
    a_disabled_no_irq: assert property (
        LINK.token && LINK.ep != 2'h0 && !s_q.enable[LINK.ep] && !WR
        |=> IN_IRQ == 3'h0)
        else $error("Disabled endpoint interrupted");
    a_out_only_silent: assert property (
        LINK.token && LINK.ep != 2'h0 && !s_q.ep[LINK.ep].split
        && !s_q.ep[LINK.ep].dir_in && !WR |=> REPLY == HS_NONE)
        else $error("OUT-only endpoint answered");
    a_data_irq: assert property (
        REPLY == HS_DATA |-> IN_IRQ != 3'h0)
        else $error("Data sent without interrupt");
    a_zlp_empty_one: assert property (
        LINK.token && LINK.ep == 2'h1 && s_q.enable[1] && s_q.ep[1].dir_in
        && !s_q.ep[1].send_stall && s_q.ep[1].slots != 2'h0 && !s_q.ep[1].held
        && !FIFO_BYTES[1] && !WR |=> REPLY == HS_ZLP)
        else $error("Zero-length packet missing");
    a_data_sent_one: assert property (
        LINK.token && LINK.ep == 2'h1 && s_q.enable[1] && s_q.ep[1].dir_in
        && !s_q.ep[1].send_stall && s_q.ep[1].slots != 2'h0 && !s_q.ep[1].held
        && FIFO_BYTES[1] && !WR |=> REPLY == HS_DATA && IN_IRQ[1])
        else $error("Ready packet not sent");
    a_ready_slot_one: assert property (
        s_q.ep[1].ready |-> s_q.ep[1].slots != 2'h0)
        else $error("Ready without packet on one");
    a_ready_slot_two: assert property (
        s_q.ep[2].ready |-> s_q.ep[2].slots != 2'h0)
        else $error("Ready without packet on two");
    a_ready_slot_three: assert property (
        s_q.ep[3].ready |-> s_q.ep[3].slots != 2'h0)
        else $error("Ready without packet on three");
    a_dbl_ready_full: assert property (
        s_q.ep[3].dbl && s_q.ep[3].ready |-> s_q.ep[3].slots == 2'h2)
        else $error("Double buffer ready with free slot");
    a_dbl_first_quiet: assert property (
        WR && ADDR == OFS_IN_CTRL_LOW && s_q.index == 2'h3 && WDATA[B_LOW_READY]
        && s_q.ep[3].dbl && s_q.ep[3].slots == 2'h0 && !LINK.token
        |=> !s_q.ep[3].ready && !IN_IRQ[3])
        else $error("First double-buffered load wrong");
    a_ack_flips_one: assert property (
        LINK.ack && s_q.ep[1].pend_ep == 2'h1 && !s_q.ep[1].force_tog
        && !LINK.token && !WR |=> s_q.ep[1].toggle != $past(s_q.ep[1].toggle))
        else $error("ACK did not flip toggle");
    a_toggle_still_one: assert property (
        !LINK.ack && !WR && !s_q.ep[1].force_tog |=> $stable(s_q.ep[1].toggle))
        else $error("Toggle moved without ACK");
    a_force_flip_one: assert property (
        LINK.token && LINK.ep == 2'h1 && s_q.enable[1] && s_q.ep[1].dir_in
        && s_q.ep[1].force_tog && !s_q.ep[1].send_stall && s_q.ep[1].slots != 2'h0
        && !s_q.ep[1].held && !LINK.ack && !WR
        |=> s_q.ep[1].toggle != $past(s_q.ep[1].toggle))
        else $error("Forced toggle did not flip");
    a_sof_releases: assert property (
        LINK.sof |=> !s_q.ep[3].held)
        else $error("Hold kept past frame start");
    a_held_no_send3: assert property (
        s_q.ep[3].held && LINK.token && LINK.ep == 2'h3 && !LINK.sof
        |=> REPLY != HS_DATA)
        else $error("Held packet sent early on three");
    a_flush_irq_three: assert property (
        WR && ADDR == OFS_IN_CTRL_LOW && s_q.index == 2'h3 && WDATA[B_LOW_FLUSH]
        && s_q.ep[3].slots != 2'h0 |=> IN_IRQ[3])
        else $error("Flush did not interrupt");
    a_flush_empty_quiet: assert property (
        WR && ADDR == OFS_IN_CTRL_LOW && s_q.index == 2'h3 && WDATA[B_LOW_FLUSH]
        && s_q.ep[3].slots == 2'h0 && !LINK.token |=> !IN_IRQ[3])
        else $error("Empty flush interrupted");
    a_enable_write: assert property (
        WR && ADDR == OFS_ENABLE_MASK |=> s_q.enable == $past(WDATA[3:1]))
        else $error("Enable write lost");
    a_index_write: assert property (
        WR && ADDR == OFS_INDEX |=> s_q.index == $past(WDATA[1:0]))
        else $error("Index write lost");
    a_bank_keep_one: assert property (
        WR && ADDR == OFS_IN_CTRL_HIGH && s_q.index != 2'h1 |=> $stable(s_q.ep[1].iso))
        else $error("Unselected bank written");
    a_iso_select: assert property (
        WR && ADDR == OFS_IN_CTRL_HIGH && s_q.index == 2'h3
        |=> s_q.ep[3].iso == $past(WDATA[B_HIGH_ISO]))
        else $error("Iso select lost");
    a_underrun_quiet: assert property (
        LINK.token && LINK.ep == 2'h3 && s_q.ep[3].iso && s_q.ep[3].slots == 2'h0
        && !s_q.ep[3].send_stall && !WR |=> !IN_IRQ[3])
        else $error("Underrun interrupted");
    c_stall: cover property (REPLY == HS_STALL);
    c_data: cover property (REPLY == HS_DATA ##[1:20] LINK.ack);
    c_underrun: cover property (s_q.ep[3].underrun);
    c_flush_irq: cover property (WR && WDATA[3] ##1 IN_IRQ != 3'h0);

endmodule : usb_endpoint_in_control

// File: tb/usb_host_model.sv
// Host stand-in: issues IN tokens, host ACKs and start-of-frame events.
// Assumes the block registers its answer on the same edge that takes a token.
`timescale 1ns/1ps
module usb_host_model
    import usb_ep_in_pkg::*;
(
    input wire logic MCLK,
    output link_ev_s LINK,
    input wire reply_e REPLY,
    input wire logic REPLY_TOGGLE,
    input wire logic [3:1] IN_IRQ
);
    initial begin
        LINK = '0;
    end

    task automatic sof();
        @(posedge MCLK);
        LINK.sof <= 1'b1;
        @(posedge MCLK);
        LINK.sof <= 1'b0;
    endtask : sof

    task automatic send_in(input logic [1:0] ep, input logic ack, output reply_e r,
        output logic tog, output logic [3:1] irq);
        @(posedge MCLK);
        LINK <= '{ep: ep, token: 1'b1, ack: 1'b0, sof: 1'b0};
        @(posedge MCLK);
        // Endpoint field scrambled once the event is gone
        LINK <= '{ep: ~ep, token: 1'b0, ack: 1'b0, sof: 1'b0};
        #1;
        r = REPLY;
        tog = REPLY_TOGGLE;
        irq = IN_IRQ;
        if (ack && (r == HS_DATA || r == HS_ZLP)) begin
            LINK <= '{ep: ep, token: 1'b0, ack: 1'b1, sof: 1'b0};
            @(posedge MCLK);
            LINK <= '{ep: ~ep, token: 1'b0, ack: 1'b0, sof: 1'b0};
        end
    endtask : send_in
endmodule : usb_host_model

// File: tb/usb_endpoint_in_control_tb.sv
// Bench for the endpoint 1-3 IN block: integer model compared at every reply.
// Assumes the host model drives the link side and the package offsets.
`timescale 1ns/1ps
module usb_endpoint_in_control_tb;
    import usb_ep_in_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:1] fifo = 3'h0;
    logic [3:1] en = 3'h7;
    logic [7:0] rdata, d;
    link_ev_s link;
    reply_e reply, r;
    logic rtog, t;
    logic [3:1] irq, in_irq, split_on, dir_in;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int upd = 0;
    int inr[4], iso[4], frc[4], dbl[4], pend[4], tog[4], stl[4], hld[4];

    always #4 mclk = ~mclk;

    usb_endpoint_in_control DUT (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr_en), .RD(rd_en), .RDATA(rdata), .LINK(link), .FIFO_BYTES(fifo),
        .REPLY(reply), .REPLY_TOGGLE(rtog), .IN_IRQ(in_irq), .SPLIT_ON(split_on),
        .DIR_IN(dir_in));
    usb_host_model host (.MCLK(mclk), .LINK(link), .REPLY(reply), .REPLY_TOGGLE(rtog),
        .IN_IRQ(in_irq));

    // ********************************************************
    // Checks and bus tasks
    // ********************************************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Bound well above the fewer than a thousand cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_rep(input reply_e got, input reply_e exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: reply %0d expected %0d", $time, got, exp);
        end
    endtask : chk_rep

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic cfg(input int ep, input logic [7:0] hi);
        wr(OFS_INDEX, 8'(ep));
        wr(OFS_IN_CTRL_HIGH, hi);
        inr[ep] = hi[B_HIGH_DIR_IN] | hi[B_HIGH_SPLIT];
        iso[ep] = hi[B_HIGH_ISO];
        frc[ep] = hi[B_HIGH_FORCE_TOGGLE];
        dbl[ep] = hi[B_HIGH_DBL_BUF];
    endtask : cfg

    task automatic ld(input int ep);
        wr(OFS_INDEX, 8'(ep));
        wr(OFS_IN_CTRL_LOW, 8'h01);
        pend[ep]++;
        hld[ep] = upd & iso[ep];
    endtask : ld

    task automatic sof();
        host.sof();
        hld = '{default: 0};
    endtask : sof

    task automatic watch(input logic [3:1] exp);
        irq = 3'h0;
        repeat (3) begin
            #1;
            irq |= in_irq;
            @(posedge mclk);
        end
        chk_reg({5'h00, irq}, {5'h00, exp});
    endtask : watch

    task automatic pkt(input int ep, input logic ack);
        reply_e e;
        logic [3:1] ie;
        host.send_in(2'(ep), ack, r, t, irq);
        e = HS_NONE;
        ie = 3'h0;
        if (en[ep] && inr[ep] != 0) begin
            if (stl[ep] != 0 || pend[ep] > 0 && hld[ep] == 0) ie[ep] = 1'b1;
            if (stl[ep] != 0) e = HS_STALL;
            else if (pend[ep] > 0 && hld[ep] == 0) e = fifo[ep] ? HS_DATA : HS_ZLP;
            else if (iso[ep] != 0) e = HS_ZLP;
        end
        chk_rep(r, e);
        chk_reg({5'h00, irq}, {5'h00, ie});
        if (e == HS_DATA || e == HS_ZLP) begin
            chk_reg({7'h00, t}, 8'(tog[ep]));
            if (ack || frc[ep] != 0) tog[ep] ^= 1;
        end
        if (ie != 3'h0 && e != HS_STALL) pend[ep]--;
    endtask : pkt

    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        int ep;
        void'($urandom(70));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_ENABLE_MASK);
        chk_reg(d, RST_ENABLE_MASK);
        rd(8'h3F);
        chk_reg(d, 8'h00);
        for (int i = 1; i <= 3; i++) cfg(i, 8'h04);
        #1;
        chk_reg({2'h0, split_on, dir_in}, 8'h38);
        for (int i = 1; i <= 3; i++) begin
            cfg(i, 8'h00);
            ld(i);
            pkt(i, 1'b0);
            cfg(i, 8'h20);
        end
        #1;
        chk_reg({2'h0, split_on, dir_in}, 8'h07);
        wr(OFS_ENABLE_MASK, 8'h01);
        en = 3'h0;
        rd(OFS_ENABLE_MASK);
        chk_reg(d, ENABLE_FIXED_ONES);
        pkt(1, 1'b1);
        wr(OFS_ENABLE_MASK, 8'h0F);
        en = 3'h7;
        for (int i = 0; i < 40; i++) begin
            ep = 1 + $urandom % 3;
            cfg(ep, 8'h20 | (8'($urandom % 2) << 3));
            if (pend[ep] == 0 && $urandom % 3 != 0) ld(ep);
            @(posedge mclk);
            fifo <= 3'($urandom);
            pkt(ep, 1'($urandom));
            rd(OFS_IN_CTRL_LOW);
            chk_reg(d & 8'h01, 8'(pend[ep] > 0));
        end
        for (int i = 1; i <= 3; i++) if (pend[i] > 0) pkt(i, 1'b0);
        wr(OFS_INDEX, 8'h01);
        wr(OFS_IN_CTRL_LOW, 8'h40);
        tog[1] = 0;
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h40, 8'h00);
        ld(1);
        pkt(1, 1'b1);
        wr(OFS_INDEX, 8'h02);
        wr(OFS_IN_CTRL_LOW, 8'h10);
        stl[2] = 1;
        repeat (2) pkt(2, 1'b1);
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h30, 8'h30);
        wr(OFS_IN_CTRL_LOW, 8'h00);
        stl[2] = 0;
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h30, 8'h00);
        @(posedge mclk);
        fifo <= 3'h7;
        ld(3);
        wr(OFS_IN_CTRL_LOW, 8'h08);
        pend[3] = 0;
        watch(3'h4);
        cfg(3, 8'hE0);
        sof();
        pkt(3, 1'b0);
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h04, 8'h04);
        ld(3);
        watch(3'h0);
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h01, 8'h00);
        ld(3);
        rd(OFS_IN_CTRL_LOW);
        chk_reg(d & 8'h01, 8'h01);
        repeat (3) begin
            sof();
            pkt(3, 1'b0);
        end
        // One iso token per frame, so open a fresh frame first
        sof();
        wr(OFS_UPDATE_CTRL, 8'h80);
        upd = 1;
        ld(3);
        pkt(3, 1'b0);
        sof();
        pkt(3, 1'b0);
        results();
    end
endmodule : usb_endpoint_in_control_tb
